// ### rtl/dyn_tmin_ctrl.sv
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module dyn_tmin_ctrl #(
  parameter int TW = 8
) (
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // AXI4-Lite write address and data
  input  wire logic [31:0]   s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // AXI4-Lite read
  input  wire logic [31:0]   s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // Device context
  input  wire logic          soft_reset,
  input  wire logic          monitor_tick,
  input  wire logic          thermal_alarm_pin_a_n,
  input  wire logic          thermal_alarm_pin_b_n,
  input  wire logic [TW-1:0] temp_sensor_a,
  input  wire logic [TW-1:0] temp_sensor_b,
  // Loop requests for threshold changes
  input  wire logic          req_dec_a,
  input  wire logic          req_inc_a,
  input  wire logic          req_dec_b,
  input  wire logic          req_inc_b,
  // Adjustment grants
  output logic               adjust_a_q,
  output logic               adjust_b_q,
  output logic               step_a_q,
  output logic               step_b_q
);
  typedef enum logic [1:0] {W_IDLE, W_RESP} wr_state_t;

  wr_state_t     wr_state_q;
  logic          aw_held_q;
  logic          w_held_q;
  logic [7:0]    aw_idx_q;
  logic [8:0]    aw_word;
  logic [8:0]    ar_word;
  logic [7:0]    w_data_q;
  logic          w_lane_q;
  logic [7:0]    ctrl_one_q;
  logic [7:0]    ctrl_two_q;
  logic          lock_q;
  logic [TW-1:0] oppt_a_q;
  logic [TW-1:0] oppt_b_q;
  logic          alarm_a_q;
  logic          alarm_b_q;
  logic          cap_a;
  logic          cap_b;
  logic          do_write;
  logic          wr_ok;

  // Word index from a byte address; misaligned or out-of-page gives no match
  function automatic logic [8:0] word_idx(input logic [31:0] addr);
    if (addr[1:0] != 2'h0 || addr[31:10] != 22'h0)
      return 9'h100;
    return {1'b0, addr[9:2]};
  endfunction

  function automatic logic mapped(input logic [8:0] idx);
    return idx == {1'b0, dyn_tmin_pkg::CTRL_ONE_IDX} || idx == {1'b0, dyn_tmin_pkg::CTRL_TWO_IDX}
        || idx == {1'b0, dyn_tmin_pkg::LOCK_IDX}     || idx == {1'b0, dyn_tmin_pkg::OPPT_A_IDX}
        || idx == {1'b0, dyn_tmin_pkg::OPPT_B_IDX}   || idx == {1'b0, dyn_tmin_pkg::STATUS_IDX};
  endfunction

  assign aw_word = word_idx(s_axi_awaddr);
  assign ar_word = word_idx(s_axi_araddr);

  // Write channel: address and data taken in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_idx_q  <= 8'h00;
      w_data_q  <= 8'h00;
      w_lane_q  <= 1'b0;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_idx_q  <= mapped(aw_word) ? aw_word[7:0] : 8'hFF;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
    end
  end

  assign do_write      = aw_held_q && w_held_q && wr_state_q == W_IDLE;
  assign wr_ok         = aw_idx_q != 8'hFF;

  // Ready launches from a flop; it tracks an idle channel with an empty holding slot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else if (do_write) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else if (wr_state_q == W_RESP) begin
      s_axi_awready <= s_axi_bready;
      s_axi_wready  <= s_axi_bready;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q   <= W_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dyn_tmin_pkg::RESP_OKAY;
    end else begin
      case (wr_state_q)
        W_IDLE: begin
          if (do_write) begin
            wr_state_q   <= W_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? dyn_tmin_pkg::RESP_OKAY : dyn_tmin_pkg::RESP_SLVERR;
          end
        end
        W_RESP: begin
          if (s_axi_bready) begin
            wr_state_q   <= W_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: wr_state_q <= W_IDLE;
      endcase
    end
  end

  // Control one: reset and soft reset clear it, lock freezes it
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      ctrl_one_q <= dyn_tmin_pkg::CTRL_ONE_RESET;
    end else if (do_write && w_lane_q && !lock_q && aw_idx_q == dyn_tmin_pkg::CTRL_ONE_IDX) begin
      ctrl_one_q <= w_data_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      ctrl_two_q <= dyn_tmin_pkg::CTRL_TWO_RESET;
    end else if (do_write && w_lane_q && !lock_q && aw_idx_q == dyn_tmin_pkg::CTRL_TWO_IDX) begin
      ctrl_two_q <= w_data_q;
    end
  end

  // Lock is sticky until a power-on reset, as a lock must survive soft reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_q <= 1'b0;
    end else if (do_write && w_lane_q && aw_idx_q == dyn_tmin_pkg::LOCK_IDX && w_data_q[0]) begin
      lock_q <= 1'b1;
    end
  end

  // Alarm pins are active low; capture on the falling edge of the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_a_q <= 1'b0;
      alarm_b_q <= 1'b0;
    end else begin
      alarm_a_q <= !thermal_alarm_pin_a_n;
      alarm_b_q <= !thermal_alarm_pin_b_n;
    end
  end

  // Reserved bits 7:6 feed nothing
  assign cap_a = (!thermal_alarm_pin_a_n && !alarm_a_q && ctrl_one_q[dyn_tmin_pkg::AA_BIT])
              || (!thermal_alarm_pin_b_n && !alarm_b_q && ctrl_one_q[dyn_tmin_pkg::BA_BIT]);
  assign cap_b = (!thermal_alarm_pin_a_n && !alarm_a_q && ctrl_one_q[dyn_tmin_pkg::AB_BIT])
              || (!thermal_alarm_pin_b_n && !alarm_b_q && ctrl_one_q[dyn_tmin_pkg::BB_BIT]);

  // Operating points: capture outranks a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      oppt_a_q <= TW'(dyn_tmin_pkg::OPPT_RESET);
    end else if (cap_a && temp_sensor_a < oppt_a_q) begin
      oppt_a_q <= temp_sensor_a;
    end else if (do_write && w_lane_q && aw_idx_q == dyn_tmin_pkg::OPPT_A_IDX) begin
      oppt_a_q <= TW'(w_data_q);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset) begin
      oppt_b_q <= TW'(dyn_tmin_pkg::OPPT_RESET);
    end else if (cap_b && temp_sensor_b < oppt_b_q) begin
      oppt_b_q <= temp_sensor_b;
    end else if (do_write && w_lane_q && aw_idx_q == dyn_tmin_pkg::OPPT_B_IDX) begin
      oppt_b_q <= TW'(w_data_q);
    end
  end

  // Pacing of threshold changes; sensor B shares the sensor A delay code
  adj_pace_if pace_a ();
  adj_pace_if pace_b ();

  assign pace_a.tick       = monitor_tick;
  assign pace_a.enable     = ctrl_one_q[dyn_tmin_pkg::EN_A_BIT];
  assign pace_a.step_dec   = req_dec_a && pace_a.allow;
  assign pace_a.step_inc   = req_inc_a && !req_dec_a && pace_a.allow;
  assign pace_a.delay_code = ctrl_two_q[dyn_tmin_pkg::DELAY_LSB +: dyn_tmin_pkg::DELAY_W];
  assign pace_b.tick       = monitor_tick;
  assign pace_b.enable     = ctrl_one_q[dyn_tmin_pkg::EN_B_BIT];
  assign pace_b.step_dec   = req_dec_b && pace_b.allow;
  assign pace_b.step_inc   = req_inc_b && !req_dec_b && pace_b.allow;
  assign pace_b.delay_code = ctrl_two_q[dyn_tmin_pkg::DELAY_LSB +: dyn_tmin_pkg::DELAY_W];

  adj_pacer u_pace_a (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pif     (pace_a.pace)
  );

  adj_pacer u_pace_b (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pif     (pace_b.pace)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adjust_a_q <= 1'b0;
      adjust_b_q <= 1'b0;
      step_a_q   <= 1'b0;
      step_b_q   <= 1'b0;
    end else begin
      adjust_a_q <= pace_a.enable;
      adjust_b_q <= pace_b.enable;
      step_a_q   <= pace_a.step_dec || pace_a.step_inc;
      step_b_q   <= pace_b.step_dec || pace_b.step_inc;
    end
  end

  // Read channel: one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= dyn_tmin_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mapped(ar_word) ? dyn_tmin_pkg::RESP_OKAY : dyn_tmin_pkg::RESP_SLVERR;
      case (ar_word)
        {1'b0, dyn_tmin_pkg::CTRL_ONE_IDX}: s_axi_rdata <= {24'h000000, ctrl_one_q};
        {1'b0, dyn_tmin_pkg::CTRL_TWO_IDX}: s_axi_rdata <= {24'h000000, ctrl_two_q};
        {1'b0, dyn_tmin_pkg::LOCK_IDX}:     s_axi_rdata <= {31'h00000000, lock_q};
        {1'b0, dyn_tmin_pkg::OPPT_A_IDX}:   s_axi_rdata <= 32'(oppt_a_q);
        {1'b0, dyn_tmin_pkg::OPPT_B_IDX}:   s_axi_rdata <= 32'(oppt_b_q);
        {1'b0, dyn_tmin_pkg::STATUS_IDX}:
          s_axi_rdata <= {28'h0000000, pace_b.allow, pace_a.allow, alarm_b_q, alarm_a_q};
        default:                            s_axi_rdata <= 32'h00000000;
      endcase
    end else begin
      // A new address is only taken once the previous data has left
      s_axi_arready <= !s_axi_rvalid || s_axi_rready;
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : dyn_tmin_ctrl

// ### rtl/dyn_tmin_pkg.sv
package dyn_tmin_pkg;

  // Register byte addresses are four times the printed index
  localparam logic [7:0]  CTRL_ONE_IDX   = 8'h0B;
  localparam logic [7:0]  CTRL_TWO_IDX   = 8'h0C;
  localparam logic [7:0]  LOCK_IDX       = 8'h10;
  localparam logic [7:0]  OPPT_A_IDX     = 8'h11;
  localparam logic [7:0]  OPPT_B_IDX     = 8'h12;
  localparam logic [7:0]  STATUS_IDX     = 8'h13;

  localparam logic [7:0]  CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0]  CTRL_TWO_RESET = 8'h00;
  localparam logic [7:0]  OPPT_RESET     = 8'h7F;

  localparam int          EN_A_BIT       = 0;
  localparam int          EN_B_BIT       = 1;
  localparam int          AA_BIT         = 2;
  localparam int          AB_BIT         = 3;
  localparam int          BA_BIT         = 4;
  localparam int          BB_BIT         = 5;
  localparam int          CTRL_ONE_USED  = 6;
  localparam int          DELAY_LSB      = 0;
  localparam int          DELAY_W        = 3;

  // Decrease wait is 8 << code, increase wait 16 << code
  localparam logic [11:0] DEC_BASE_CYC   = 12'h008;
  localparam logic [11:0] INC_BASE_CYC   = 12'h010;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage : dyn_tmin_pkg

// ### rtl/adj_pace_if.sv
`timescale 1ns/1ps
interface adj_pace_if;
  logic       tick;
  logic       enable;
  logic       step_dec;
  logic       step_inc;
  logic [2:0] delay_code;
  logic       allow;
  modport pace (input tick, enable, step_dec, step_inc, delay_code, output allow);
  modport user (output tick, enable, step_dec, step_inc, delay_code, input allow);
endinterface : adj_pace_if

// ### rtl/adj_pacer.sv
`timescale 1ns/1ps
// Counts monitoring cycles after each threshold change of one channel
module adj_pacer (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Pacing handshake
  adj_pace_if.pace  pif
);
  logic [11:0] left_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_q <= 12'h000;
    end else if (!pif.enable) begin
      left_q <= 12'h000;
    end else if (pif.step_dec) begin
      left_q <= dyn_tmin_pkg::DEC_BASE_CYC << pif.delay_code;
    end else if (pif.step_inc) begin
      left_q <= dyn_tmin_pkg::INC_BASE_CYC << pif.delay_code;
    end else if (pif.tick && left_q != 12'h000) begin
      left_q <= left_q - 12'h001;
    end
  end

  assign pif.allow = pif.enable && (left_q == 12'h000);
endmodule : adj_pacer

// ### dv/dyn_tmin_ctrl_props.sv
`timescale 1ns/1ps
// Bus handshake and grant timing as seen at the block's pins
module dyn_tmin_ctrl_props (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Grants
  input wire logic        adjust_a_q,
  input wire logic        adjust_b_q,
  input wire logic        step_a_q,
  input wire logic        step_b_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_write_answer: assert property (write_taken |-> ##[1:2] s_axi_bvalid)
    else $error("no write response");
  a_read_answer: assert property (read_taken |=> s_axi_rvalid) else $error("no read data");
  a_busy_no_take: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_step_single: assert property (step_a_q |=> !step_a_q) else $error("step repeated");
  a_step_en_a: assert property (step_a_q |-> adjust_a_q || $past(adjust_a_q))
    else $error("step without enable a");
  a_step_en_b: assert property (step_b_q |-> adjust_b_q || $past(adjust_b_q))
    else $error("step without enable b");
endmodule // dyn_tmin_ctrl_props

bind dyn_tmin_ctrl dyn_tmin_ctrl_props dyn_tmin_ctrl_props_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .adjust_a_q(adjust_a_q), .adjust_b_q(adjust_b_q),
  .step_a_q(step_a_q), .step_b_q(step_b_q)
);

// ### dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, soft_reset, monitor_tick, thermal_alarm_pin_a_n;
  logic        thermal_alarm_pin_b_n, req_dec_a, req_inc_a, req_dec_b, req_inc_b;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        adjust_a_q, adjust_b_q, step_a_q, step_b_q;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  temp_sensor_a, temp_sensor_b, ta, tb_t;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  int          fail_count, comparisons, seed, ticks, cyc, i, c, t0, t1, na, nb;
  localparam logic [7:0] C1 = dyn_tmin_pkg::CTRL_ONE_IDX;
  localparam logic [7:0] C2 = dyn_tmin_pkg::CTRL_TWO_IDX;
  localparam logic [7:0] OPA = dyn_tmin_pkg::OPPT_A_IDX;
  localparam logic [7:0] OPB = dyn_tmin_pkg::OPPT_B_IDX;

  dyn_tmin_ctrl dyn_tmin_ctrl_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .soft_reset(soft_reset),
    .monitor_tick(monitor_tick), .thermal_alarm_pin_a_n(thermal_alarm_pin_a_n),
    .thermal_alarm_pin_b_n(thermal_alarm_pin_b_n), .temp_sensor_a(temp_sensor_a),
    .temp_sensor_b(temp_sensor_b), .req_dec_a(req_dec_a), .req_inc_a(req_inc_a),
    .req_dec_b(req_dec_b), .req_inc_b(req_inc_b), .adjust_a_q(adjust_a_q),
    .adjust_b_q(adjust_b_q), .step_a_q(step_a_q), .step_b_q(step_b_q)
  );

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // Ticks every fourth cycle, so a grant cycle never coincides with a tick
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    monitor_tick <= (cyc % 4 == 3);
    if (monitor_tick) ticks <= ticks + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Monitoring ticks between two granted changes for a given direction and code
  function automatic int wait_cycles(input logic inc, input int code);
    return int'(inc ? dyn_tmin_pkg::INC_BASE_CYC : dyn_tmin_pkg::DEC_BASE_CYC) << code;
  endfunction
  task automatic wchk(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic aw;
    logic w;
    @(posedge aclk);
    s_axi_awaddr <= {22'h0, idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw = s_axi_awready;
      w = s_axi_wready;
      @(posedge aclk);
      if (aw === 1'b1) s_axi_awvalid <= 1'b0;
      if (w === 1'b1) s_axi_wvalid <= 1'b0;
    end while (!((aw === 1'b1 || !s_axi_awvalid) && (w === 1'b1 || !s_axi_wvalid)));
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk({30'h0, rsp}, {30'h0, er});
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= {22'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk(rd, e);
    chk({30'h0, rsp}, {30'h0, er});
  endtask
  task automatic next_step(output int t);
    @(negedge aclk);
    while (step_a_q !== 1'b1) @(negedge aclk);
    t = ticks;
  endtask
  task automatic fire(input int pin);
    @(posedge aclk);
    if (pin == 0) thermal_alarm_pin_a_n <= 1'b0;
    else thermal_alarm_pin_b_n <= 1'b0;
    repeat (3) @(posedge aclk);
    thermal_alarm_pin_a_n <= 1'b1;
    thermal_alarm_pin_b_n <= 1'b1;
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge aclk);
    fail_count++;
    $display("wrong value at %0t: run did not finish", $time);
    tally_and_finish();
  end

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {soft_reset, req_dec_a, req_inc_a, req_dec_b, req_inc_b} = 5'h00;
    {thermal_alarm_pin_a_n, thermal_alarm_pin_b_n} = 2'h3;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    s_axi_wstrb = 4'hF;
    {temp_sensor_a, temp_sensor_b} = 16'h0;
    {fail_count, comparisons} = 64'h0;
    seed = 32'hD546;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(C1, 32'h00, dyn_tmin_pkg::RESP_OKAY);
    rchk(8'h01, 32'h00, dyn_tmin_pkg::RESP_SLVERR);
    wchk(C1, 32'hC0, dyn_tmin_pkg::RESP_OKAY);
    rchk(C1, 32'hC0, dyn_tmin_pkg::RESP_OKAY);
    chk({adjust_b_q, adjust_a_q}, 2'h0);
    // Six cases: each selector alone, none, all with temperatures not below
    for (i = 0; i < 6; i++) begin
      wchk(C1, i < 4 ? 32'h04 << i : (i == 4 ? 32'h00 : 32'h3C), dyn_tmin_pkg::RESP_OKAY);
      wchk(OPA, 32'h50, dyn_tmin_pkg::RESP_OKAY);
      wchk(OPB, 32'h50, dyn_tmin_pkg::RESP_OKAY);
      ta = (i == 5) ? 8'h50 : 8'($random(seed) & 32'h3F);
      tb_t = (i == 5) ? 8'h60 : 8'($random(seed) & 32'h3F);
      temp_sensor_a <= ta;
      temp_sensor_b <= tb_t;
      fire(0);
      fire(1);
      rchk(OPA, (i == 0 || i == 2) ? ta : 8'h50, dyn_tmin_pkg::RESP_OKAY);
      rchk(OPB, (i == 1 || i == 3) ? tb_t : 8'h50, dyn_tmin_pkg::RESP_OKAY);
    end
    wchk(C1, 32'h01, dyn_tmin_pkg::RESP_OKAY);
    @(negedge aclk);
    chk({adjust_b_q, adjust_a_q}, 2'h1);
    @(posedge aclk);
    req_dec_a <= 1'b1;
    for (c = 0; c < 8; c++) begin
      wchk(C2, c, dyn_tmin_pkg::RESP_OKAY);
      next_step(t0);
      next_step(t1);
      chk(32'(t1 - t0), 32'(wait_cycles(1'b0, c)));
    end
    @(posedge aclk);
    req_dec_a <= 1'b0;
    req_inc_a <= 1'b1;
    c = $random(seed) & 7;
    wchk(C2, c, dyn_tmin_pkg::RESP_OKAY);
    next_step(t0);
    next_step(t1);
    chk(32'(t1 - t0), 32'(wait_cycles(1'b1, c)));
    wchk(C2, 32'h0, dyn_tmin_pkg::RESP_OKAY);
    wchk(C1, 32'h02, dyn_tmin_pkg::RESP_OKAY);
    req_dec_b <= 1'b1;
    {na, nb} = 64'h0;
    repeat (200) begin
      @(negedge aclk);
      na += step_a_q;
      nb += step_b_q;
    end
    chk(32'(na), 32'h0);
    chk(32'(nb > 0), 32'h1);
    chk({adjust_b_q, adjust_a_q}, 2'h2);
    @(posedge aclk);
    soft_reset <= 1'b1;
    @(posedge aclk);
    soft_reset <= 1'b0;
    rchk(OPA, {24'h000000, dyn_tmin_pkg::OPPT_RESET}, dyn_tmin_pkg::RESP_OKAY);
    rchk(C1, 32'h00, dyn_tmin_pkg::RESP_OKAY);
    wchk(dyn_tmin_pkg::LOCK_IDX, 32'h01, dyn_tmin_pkg::RESP_OKAY);
    wchk(C1, 32'h03, dyn_tmin_pkg::RESP_OKAY);
    rchk(C1, 32'h00, dyn_tmin_pkg::RESP_OKAY);
    rchk(dyn_tmin_pkg::LOCK_IDX, 32'h01, dyn_tmin_pkg::RESP_OKAY);
    rchk(dyn_tmin_pkg::STATUS_IDX, 32'h00, dyn_tmin_pkg::RESP_OKAY);
    tally_and_finish();
  end
endmodule // tb
